// ---- design/bma_regs.svh ----
// constants for the bit-manipulation alu
`ifndef BMA_REGS_SVH
`define BMA_REGS_SVH
`define BMA_REGISTER_WIDTH   64
`define BMA_WORD_WIDTH       32
`define BMA_HALF_WIDTH       16
`define BMA_BYTE_WIDTH       8
`define BMA_BYTES            8
`define BMA_INDEX_WIDTH      6
`define BMA_WORD_INDEX_WIDTH 5
`define BMA_COUNT_WIDTH      7
`define BMA_SHAMT_HIGH_BIT   5
`define BMA_RESULT_RESET     64'h0
`define BMA_COUNT_ONE        7'h01
`endif

// ---- design/bma_pkg.sv ----
// types shared by the bit-manipulation alu
`include "bma_regs.svh"
package bma_pkg;

  typedef logic [`BMA_REGISTER_WIDTH-1:0]   bma_word_t;
  typedef logic [2*`BMA_REGISTER_WIDTH-1:0] bma_dword_t;

  typedef enum logic [5:0] {
    BMA_OP_ANDN,
    BMA_OP_ORN,
    BMA_OP_XNOR,
    BMA_OP_CLZ,
    BMA_OP_CLZW,
    BMA_OP_CTZ,
    BMA_OP_CTZW,
    BMA_OP_CPOP,
    BMA_OP_CPOPW,
    BMA_OP_MIN,
    BMA_OP_MINU,
    BMA_OP_MAX,
    BMA_OP_MAXU,
    BMA_OP_SEXT_BYTE,
    BMA_OP_SEXT_HALF,
    BMA_OP_ZEXT_HALF,
    BMA_OP_ROL,
    BMA_OP_ROLW,
    BMA_OP_ROR,
    BMA_OP_RORW,
    BMA_OP_RORI,
    BMA_OP_RORIW,
    BMA_OP_OR_COMBINE,
    BMA_OP_BYTE_REVERSE,
    BMA_OP_CLMUL,
    BMA_OP_CLMULH,
    BMA_OP_CLMULR,
    BMA_OP_BCLR,
    BMA_OP_BEXT,
    BMA_OP_BINV,
    BMA_OP_BSET,
    BMA_OP_PACK,
    BMA_OP_PACKH,
    BMA_OP_PACKW,
    BMA_OP_REV_BITS
  } bma_op_e;

  typedef struct packed {
    logic      valid;
    logic      illegal;
    bma_word_t result;
  } bma_state_s;

endpackage : bma_pkg

// ---- design/bma_clmul.sv ----
// carry-less multiplier, double-width product
`timescale 1ns/1ps
`default_nettype none
`include "bma_regs.svh"
module bma_clmul (
  input  wire logic [`BMA_REGISTER_WIDTH-1:0]   a_i,
  input  wire logic [`BMA_REGISTER_WIDTH-1:0]   b_i,
  output var  logic [2*`BMA_REGISTER_WIDTH-1:0] product_o
);

  // partial products joined by xor, no carries
  always_comb begin
    product_o = '0;
    for (int i = 0; i < `BMA_REGISTER_WIDTH; i++) begin
      if (b_i[i]) begin
        product_o = product_o ^ ({{`BMA_REGISTER_WIDTH{1'b0}}, a_i} << i);
      end
    end
  end

endmodule : bma_clmul
`default_nettype wire

// ---- design/bma_alu.sv ----
// bit-manipulation execution unit, one registered result per operation
//
// Function
// - andn, orn, xnor use the complement of the second source.
// - count zeros above the top set bit or below the lowest set bit.
// - word counts exist in base_64bit only, on the low 32-bit word.
// - population count returns the number of one bits.
// - min and max of both sources, signed and unsigned variants.
// - sign-extend low byte or halfword, zero-extend low halfword.
// - rotates refill vacated bits with the bits shifted out.
// - rotate left/right by register, right by immediate; word forms 64-bit only.
// - or-combine sets a byte to all ones if any of its bits is set.
// - byte_reverse reverses byte order across the register width.
// - carry-less product combines partial products by xor.
// - low carry-less multiply returns the low half of the product.
// - high carry-less multiply returns the upper half of the product.
// - reversed carry-less multiply returns product bits 2w-2 down to w-1.
// - single-bit set, clear, invert or extract at an index.
// - single-bit index from second source or immediate, both bases.
// - pack joins low halves; pack-byte joins low bytes of both sources.
// - in base_64bit only, word pack joins the low 16 bits of both sources.
// - bit reverse inside every byte, bytes keep their positions.
// - crypto-only configuration lacks the reversed carry-less multiply.
// - register index uses the low log2(width) bits of the second source.
// - in base_32bit an immediate index with bit five set is reserved.
`timescale 1ns/1ps
`default_nettype none
`include "bma_regs.svh"
module bma_alu (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_n_i,
  input  wire logic                                    en_i,
  input  wire logic                                    valid_i,
  input  wire bma_pkg::bma_op_e                        op_i,
  input  wire logic [`BMA_REGISTER_WIDTH-1:0]          first_source_i,
  input  wire logic [`BMA_REGISTER_WIDTH-1:0]          second_source_i,
  input  wire logic [`BMA_INDEX_WIDTH-1:0]             imm_i,
  input  wire logic                                    use_imm_i,
  input  wire logic                                    base_32bit_i,
  input  wire logic                                    crypto_only_i,
  output var  logic                                    valid_o,
  output var  logic                                    illegal_o,
  output var  logic [`BMA_REGISTER_WIDTH-1:0]          result_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // leading zeros of full width or of low word
  function automatic logic [`BMA_COUNT_WIDTH-1:0] bma_clz(
    input bma_pkg::bma_word_t x,
    input logic               word
  );
    logic [`BMA_COUNT_WIDTH-1:0] n;
    logic                        done;
    n    = '0;
    done = 1'b0;
    for (int i = `BMA_REGISTER_WIDTH - 1; i >= 0; i--) begin
      if (!(word && i >= `BMA_WORD_WIDTH) && !done) begin
        if (x[i]) begin
          done = 1'b1;
        end else begin
          n = n + `BMA_COUNT_ONE;
        end
      end
    end
    return n;
  endfunction : bma_clz

  // trailing zeros of full width or of low word
  function automatic logic [`BMA_COUNT_WIDTH-1:0] bma_ctz(
    input bma_pkg::bma_word_t x,
    input logic               word
  );
    logic [`BMA_COUNT_WIDTH-1:0] n;
    logic                        done;
    n    = '0;
    done = 1'b0;
    for (int i = 0; i < `BMA_REGISTER_WIDTH; i++) begin
      if (!(word && i >= `BMA_WORD_WIDTH) && !done) begin
        if (x[i]) begin
          done = 1'b1;
        end else begin
          n = n + `BMA_COUNT_ONE;
        end
      end
    end
    return n;
  endfunction : bma_ctz

  // one bits of full width or of low word
  function automatic logic [`BMA_COUNT_WIDTH-1:0] bma_cpop(
    input bma_pkg::bma_word_t x,
    input logic               word
  );
    logic [`BMA_COUNT_WIDTH-1:0] n;
    n = '0;
    for (int i = 0; i < `BMA_REGISTER_WIDTH; i++) begin
      if (!(word && i >= `BMA_WORD_WIDTH) && x[i]) begin
        n = n + `BMA_COUNT_ONE;
      end
    end
    return n;
  endfunction : bma_cpop

  // rotate right, amount wraps at the operand width
  function automatic bma_pkg::bma_word_t bma_ror(
    input bma_pkg::bma_word_t           x,
    input logic [`BMA_INDEX_WIDTH-1:0]  n,
    input logic                         word
  );
    bma_pkg::bma_dword_t t;
    if (word) begin
      t = {{`BMA_REGISTER_WIDTH{1'b0}}, x[`BMA_WORD_WIDTH-1:0], x[`BMA_WORD_WIDTH-1:0]}
          >> n[`BMA_WORD_INDEX_WIDTH-1:0];
      return {{`BMA_WORD_WIDTH{1'b0}}, t[`BMA_WORD_WIDTH-1:0]};
    end
    t = {x, x} >> n;
    return t[`BMA_REGISTER_WIDTH-1:0];
  endfunction : bma_ror

  // byte order reversed over the full width
  function automatic bma_pkg::bma_word_t bma_byte_reverse(input bma_pkg::bma_word_t x);
    bma_pkg::bma_word_t y;
    y = '0;
    for (int i = 0; i < `BMA_BYTES; i++) begin
      y[i*`BMA_BYTE_WIDTH +: `BMA_BYTE_WIDTH] = x[(`BMA_BYTES-1-i)*`BMA_BYTE_WIDTH +: `BMA_BYTE_WIDTH];
    end
    return y;
  endfunction : bma_byte_reverse

  // sign extension of a low word
  function automatic bma_pkg::bma_word_t bma_sext_word(input logic [`BMA_WORD_WIDTH-1:0] x);
    return {{(`BMA_REGISTER_WIDTH-`BMA_WORD_WIDTH){x[`BMA_WORD_WIDTH-1]}}, x};
  endfunction : bma_sext_word

  ////////////////////////////////////////////////////////////////////////////
  // operand preparation

  bma_pkg::bma_state_s          state;
  bma_pkg::bma_state_s          next_state;
  bma_pkg::bma_word_t           a;
  bma_pkg::bma_word_t           b;
  bma_pkg::bma_word_t           cl_a;
  bma_pkg::bma_word_t           cl_b;
  bma_pkg::bma_dword_t          cl_prod;
  logic [`BMA_INDEX_WIDTH-1:0]  bit_index;
  logic                         word_op;
  logic                         bit_op;
  logic                         reserved;

  always_comb begin
    a = first_source_i;
    b = second_source_i;
    if (base_32bit_i) begin
      a = {{`BMA_WORD_WIDTH{1'b0}}, first_source_i[`BMA_WORD_WIDTH-1:0]};
      b = {{`BMA_WORD_WIDTH{1'b0}}, second_source_i[`BMA_WORD_WIDTH-1:0]};
    end
  end

  // carry-less operands, low word only in base_32bit
  assign cl_a = a;
  assign cl_b = b;

  bma_clmul u_clmul (
    .a_i       (cl_a),
    .b_i       (cl_b),
    .product_o (cl_prod)
  );

  // index from immediate or second source, low log2 bits only
  always_comb begin
    bit_index = use_imm_i ? imm_i : second_source_i[`BMA_INDEX_WIDTH-1:0];
    if (base_32bit_i) begin
      bit_index[`BMA_SHAMT_HIGH_BIT] = 1'b0;
    end
  end

  // operation classes
  always_comb begin
    word_op = 1'b0;
    bit_op  = 1'b0;
    case (op_i)
      bma_pkg::BMA_OP_CLZW,
      bma_pkg::BMA_OP_CTZW,
      bma_pkg::BMA_OP_CPOPW,
      bma_pkg::BMA_OP_ROLW,
      bma_pkg::BMA_OP_RORW,
      bma_pkg::BMA_OP_RORIW,
      bma_pkg::BMA_OP_PACKW: begin
        word_op = 1'b1;
      end
      bma_pkg::BMA_OP_BCLR,
      bma_pkg::BMA_OP_BEXT,
      bma_pkg::BMA_OP_BINV,
      bma_pkg::BMA_OP_BSET: begin
        bit_op = 1'b1;
      end
      default: word_op = 1'b0;
    endcase
  end

  // reserved encodings and missing operations
  always_comb begin
    reserved = 1'b0;
    if (base_32bit_i && word_op) begin
      reserved = 1'b1;
    end
    if (base_32bit_i && bit_op && use_imm_i && imm_i[`BMA_SHAMT_HIGH_BIT]) begin
      reserved = 1'b1;
    end
    if (crypto_only_i && op_i == bma_pkg::BMA_OP_CLMULR) begin
      reserved = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    bma_pkg::bma_word_t r;
    bma_pkg::bma_word_t sa;
    bma_pkg::bma_word_t sb;
    logic               lt_s;
    logic               lt_u;
    r          = '0;
    sa         = base_32bit_i ? bma_sext_word(a[`BMA_WORD_WIDTH-1:0]) : a;
    sb         = base_32bit_i ? bma_sext_word(b[`BMA_WORD_WIDTH-1:0]) : b;
    lt_s       = $signed(sa) < $signed(sb);
    lt_u       = a < b;
    next_state = state;
    if (en_i) begin
      next_state.valid   = valid_i;
      next_state.illegal = valid_i && reserved;
      case (op_i)
        bma_pkg::BMA_OP_ANDN:  r = a & ~b;
        bma_pkg::BMA_OP_ORN:   r = a | ~b;
        bma_pkg::BMA_OP_XNOR:  r = a ^ ~b;
        bma_pkg::BMA_OP_CLZ: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_COUNT_WIDTH){1'b0}}, bma_clz(a, base_32bit_i)};
        end
        bma_pkg::BMA_OP_CLZW: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_COUNT_WIDTH){1'b0}}, bma_clz(a, 1'b1)};
        end
        bma_pkg::BMA_OP_CTZ: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_COUNT_WIDTH){1'b0}}, bma_ctz(a, base_32bit_i)};
        end
        bma_pkg::BMA_OP_CTZW: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_COUNT_WIDTH){1'b0}}, bma_ctz(a, 1'b1)};
        end
        bma_pkg::BMA_OP_CPOP: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_COUNT_WIDTH){1'b0}}, bma_cpop(a, base_32bit_i)};
        end
        bma_pkg::BMA_OP_CPOPW: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_COUNT_WIDTH){1'b0}}, bma_cpop(a, 1'b1)};
        end
        bma_pkg::BMA_OP_MIN:   r = lt_s ? a : b;
        bma_pkg::BMA_OP_MINU:  r = lt_u ? a : b;
        bma_pkg::BMA_OP_MAX:   r = lt_s ? b : a;
        bma_pkg::BMA_OP_MAXU:  r = lt_u ? b : a;
        bma_pkg::BMA_OP_SEXT_BYTE: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_BYTE_WIDTH){a[`BMA_BYTE_WIDTH-1]}},
               a[`BMA_BYTE_WIDTH-1:0]};
        end
        bma_pkg::BMA_OP_SEXT_HALF: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_HALF_WIDTH){a[`BMA_HALF_WIDTH-1]}},
               a[`BMA_HALF_WIDTH-1:0]};
        end
        bma_pkg::BMA_OP_ZEXT_HALF: begin
          r = {{(`BMA_REGISTER_WIDTH-`BMA_HALF_WIDTH){1'b0}}, a[`BMA_HALF_WIDTH-1:0]};
        end
        bma_pkg::BMA_OP_ROL: begin
          r = bma_ror(a, -b[`BMA_INDEX_WIDTH-1:0], base_32bit_i);
        end
        bma_pkg::BMA_OP_ROLW: begin
          r = bma_ror(a, -b[`BMA_INDEX_WIDTH-1:0], 1'b1);
        end
        bma_pkg::BMA_OP_ROR: begin
          r = bma_ror(a, b[`BMA_INDEX_WIDTH-1:0], base_32bit_i);
        end
        bma_pkg::BMA_OP_RORW: begin
          r = bma_ror(a, b[`BMA_INDEX_WIDTH-1:0], 1'b1);
        end
        bma_pkg::BMA_OP_RORI: begin
          r = bma_ror(a, imm_i, base_32bit_i);
        end
        bma_pkg::BMA_OP_RORIW: begin
          r = bma_ror(a, imm_i, 1'b1);
        end
        bma_pkg::BMA_OP_OR_COMBINE: begin
          for (int i = 0; i < `BMA_BYTES; i++) begin
            r[i*`BMA_BYTE_WIDTH +: `BMA_BYTE_WIDTH] =
              {`BMA_BYTE_WIDTH{|a[i*`BMA_BYTE_WIDTH +: `BMA_BYTE_WIDTH]}};
          end
        end
        bma_pkg::BMA_OP_BYTE_REVERSE: begin
          r = bma_byte_reverse(a);
          if (base_32bit_i) begin
            r = {{`BMA_WORD_WIDTH{1'b0}}, r[`BMA_REGISTER_WIDTH-1:`BMA_WORD_WIDTH]};
          end
        end
        bma_pkg::BMA_OP_CLMUL: r = cl_prod[`BMA_REGISTER_WIDTH-1:0];
        bma_pkg::BMA_OP_CLMULH: begin
          r = base_32bit_i
            ? {{`BMA_WORD_WIDTH{1'b0}}, cl_prod[2*`BMA_WORD_WIDTH-1:`BMA_WORD_WIDTH]}
            : cl_prod[2*`BMA_REGISTER_WIDTH-1:`BMA_REGISTER_WIDTH];
        end
        bma_pkg::BMA_OP_CLMULR: begin
          r = base_32bit_i
            ? {{`BMA_WORD_WIDTH{1'b0}}, cl_prod[2*`BMA_WORD_WIDTH-2:`BMA_WORD_WIDTH-1]}
            : cl_prod[2*`BMA_REGISTER_WIDTH-2:`BMA_REGISTER_WIDTH-1];
        end
        bma_pkg::BMA_OP_BCLR: r = a & ~(`BMA_REGISTER_WIDTH'(1) << bit_index);
        bma_pkg::BMA_OP_BSET: r = a | (`BMA_REGISTER_WIDTH'(1) << bit_index);
        bma_pkg::BMA_OP_BINV: r = a ^ (`BMA_REGISTER_WIDTH'(1) << bit_index);
        bma_pkg::BMA_OP_BEXT: r = {{(`BMA_REGISTER_WIDTH-1){1'b0}}, a[bit_index]};
        bma_pkg::BMA_OP_PACK: begin
          r = base_32bit_i
            ? {{`BMA_WORD_WIDTH{1'b0}}, b[`BMA_HALF_WIDTH-1:0], a[`BMA_HALF_WIDTH-1:0]}
            : {b[`BMA_WORD_WIDTH-1:0], a[`BMA_WORD_WIDTH-1:0]};
        end
        bma_pkg::BMA_OP_PACKH: begin
          r = {{(`BMA_REGISTER_WIDTH-2*`BMA_BYTE_WIDTH){1'b0}},
               b[`BMA_BYTE_WIDTH-1:0], a[`BMA_BYTE_WIDTH-1:0]};
        end
        bma_pkg::BMA_OP_PACKW: begin
          r = {{`BMA_WORD_WIDTH{1'b0}}, b[`BMA_HALF_WIDTH-1:0], a[`BMA_HALF_WIDTH-1:0]};
        end
        bma_pkg::BMA_OP_REV_BITS: begin
          for (int i = 0; i < `BMA_REGISTER_WIDTH; i++) begin
            r[i] = a[(i / `BMA_BYTE_WIDTH) * `BMA_BYTE_WIDTH
                     + (`BMA_BYTE_WIDTH - 1 - i % `BMA_BYTE_WIDTH)];
          end
        end
        default: r = '0;
      endcase
      // word results widened by sign, base_32bit keeps upper bits zero
      if (base_32bit_i) begin
        r = {{`BMA_WORD_WIDTH{1'b0}}, r[`BMA_WORD_WIDTH-1:0]};
      end else if (word_op) begin
        r = bma_sext_word(r[`BMA_WORD_WIDTH-1:0]);
      end
      if (valid_i) begin
        next_state.result = reserved ? `BMA_RESULT_RESET : r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '{valid: 1'b0, illegal: 1'b0, result: `BMA_RESULT_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign valid_o   = state.valid;
  assign illegal_o = state.illegal;
  assign result_o  = state.result;

endmodule : bma_alu
`default_nettype wire

// ---- testbench/bma_alu_asserts.sv ----
// concurrent checks on the bit-manipulation alu ports
`timescale 1ns/1ps
`default_nettype none
module bma_alu_asserts (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              en_i,
  input wire logic              valid_i,
  input wire bma_pkg::bma_op_e  op_i,
  input wire logic [63:0]       first_source_i,
  input wire logic [63:0]       second_source_i,
  input wire logic [5:0]        imm_i,
  input wire logic              use_imm_i,
  input wire logic              base_32bit_i,
  input wire logic              crypto_only_i,
  input wire logic              valid_o,
  input wire logic              illegal_o,
  input wire logic [63:0]       result_o
);
  typedef logic [63:0] bma_w64_t;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_answer;
    en_i && valid_i |=> valid_o;
  endproperty
  property p_idle;
    en_i && !valid_i |=> !valid_o && !illegal_o && $stable(result_o);
  endproperty
  property p_freeze;
    !en_i |=> $stable(valid_o) && $stable(illegal_o) && $stable(result_o);
  endproperty
  property p_illegal_zero;
    illegal_o |-> valid_o && result_o == 64'h0;
  endproperty
  property p_clmulr_absent;
    en_i && valid_i && op_i == bma_pkg::BMA_OP_CLMULR && crypto_only_i |=> illegal_o;
  endproperty
  property p_word_refused;
    en_i && valid_i && base_32bit_i && op_i inside {bma_pkg::BMA_OP_CLZW, bma_pkg::BMA_OP_CTZW,
      bma_pkg::BMA_OP_CPOPW, bma_pkg::BMA_OP_ROLW, bma_pkg::BMA_OP_RORW, bma_pkg::BMA_OP_RORIW,
      bma_pkg::BMA_OP_PACKW} |=> illegal_o;
  endproperty
  property p_imm_reserved;
    en_i && valid_i && base_32bit_i && use_imm_i && imm_i[5] && op_i inside {bma_pkg::BMA_OP_BCLR,
      bma_pkg::BMA_OP_BEXT, bma_pkg::BMA_OP_BINV, bma_pkg::BMA_OP_BSET} |=> illegal_o;
  endproperty
  property p_andn;
    en_i && valid_i && !base_32bit_i && op_i == bma_pkg::BMA_OP_ANDN
      |=> result_o == ($past(first_source_i) & ~$past(second_source_i));
  endproperty
  property p_cpop;
    en_i && valid_i && !base_32bit_i && op_i == bma_pkg::BMA_OP_CPOP
      |=> result_o == 64'($countones($past(first_source_i)));
  endproperty
  property p_byte_reverse;
    en_i && valid_i && !base_32bit_i && op_i == bma_pkg::BMA_OP_BYTE_REVERSE
      |=> result_o == bma_w64_t'({<<8{$past(first_source_i)}});
  endproperty

  a_answer: assert property (p_answer)
    else $error("no result one cycle after a taken request");
  a_idle: assert property (p_idle)
    else $error("output changed without a request");
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while disabled");
  a_illegal_zero: assert property (p_illegal_zero)
    else $error("refused operation gave nonzero result");
  a_clmulr_absent: assert property (p_clmulr_absent)
    else $error("reversed carry-less multiply accepted in crypto-only mode");
  a_word_refused: assert property (p_word_refused)
    else $error("word operation accepted in 32-bit base");
  a_imm_reserved: assert property (p_imm_reserved)
    else $error("reserved immediate index accepted");
  a_andn: assert property (p_andn)
    else $error("and-not result wrong");
  a_cpop: assert property (p_cpop)
    else $error("population count wrong");
  a_byte_reverse: assert property (p_byte_reverse)
    else $error("byte reverse wrong");

  c_refused: cover property (en_i && valid_i && op_i == bma_pkg::BMA_OP_CLMULR && crypto_only_i ##1 illegal_o);
  c_back_to_back: cover property (valid_o ##1 valid_o ##1 valid_o);
  c_frozen: cover property (valid_o && !en_i ##1 valid_o);
endmodule : bma_alu_asserts

bind bma_alu bma_alu_asserts bma_alu_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
  .valid_i(valid_i), .op_i(op_i), .first_source_i(first_source_i), .second_source_i(second_source_i),
  .imm_i(imm_i), .use_imm_i(use_imm_i), .base_32bit_i(base_32bit_i), .crypto_only_i(crypto_only_i),
  .valid_o(valid_o), .illegal_o(illegal_o), .result_o(result_o));
`default_nettype wire

// ---- testbench/bma_wb_model.sv ----
// writeback model standing for the pipeline destination register
`timescale 1ns/1ps
`default_nettype none
module bma_wb_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        valid_i,
  input  wire logic        illegal_i,
  input  wire logic [63:0] result_i,
  output var  logic [63:0] dest_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      dest_o <= 64'h0;
    else if (valid_i && !illegal_i)
      dest_o <= result_i;
  end
endmodule : bma_wb_model
`default_nettype wire

// ---- testbench/bit_manipulation_alu_test.sv ----
// self-checking bench for the bit-manipulation alu
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_alu_test;
  logic             clk, rst_n, en, vld, ui, b32, cr, vo, io, pv, pe, ev, ei;
  bma_pkg::bma_op_e op, oe;
  logic [63:0]      a, b, ro, wb, er, wexp;
  logic [5:0]       imm;
  logic [64:0]      pexp;
  int               errors, checked;
  logic [63:0]      ca [8] = '{64'h0, 64'hffff_ffff_ffff_ffff, 64'h8000_0000_0000_0001, 64'h0123_4567_89ab_cdef,
                               64'h0000_0000_8000_0080, 64'h00ff_0000_0000_ff00, 64'h7fff_ffff_ffff_ffff, 64'h1};
  logic [63:0]      cb [8] = '{64'h0, 64'hffff_ffff_ffff_ffc1, 64'h3f, 64'h8000_0000_0000_0000,
                               64'h20, 64'hffff_ffff_ffff_ffff, 64'h1f, 64'h0000_0001_0000_0003};
  logic [5:0]       ci [8] = '{6'h3f, 6'h20, 6'h00, 6'h1f, 6'h21, 6'h01, 6'h3e, 6'h10};

  bma_alu bma_alu_inst (.clk_i(clk), .rst_n_i(rst_n), .en_i(en), .valid_i(vld), .op_i(op),
    .first_source_i(a), .second_source_i(b), .imm_i(imm), .use_imm_i(ui), .base_32bit_i(b32),
    .crypto_only_i(cr), .valid_o(vo), .illegal_o(io), .result_o(ro));
  bma_wb_model bma_wb_model_inst (.clk_i(clk), .rst_n_i(rst_n), .valid_i(vo), .illegal_i(io),
    .result_i(ro), .dest_o(wb));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] rotl(input logic [63:0] x, input int k, w, input logic [63:0] m);
    return ((x << k) | (x >> ((w - k) % w))) & m;
  endfunction : rotl

  function automatic logic [64:0] model(input bma_pkg::bma_op_e o, input logic [63:0] x, y,
                                        input logic [5:0] im, input logic u, w32, c);
    logic [127:0] p;
    logic [63:0]  r, m, xa, yb;
    logic [64:0]  t;
    logic         ill, wd, lt;
    int           w, n, ki, kr;
    wd = 1'b1;
    case (o)
      bma_pkg::BMA_OP_CLZW: o = bma_pkg::BMA_OP_CLZ;
      bma_pkg::BMA_OP_CTZW: o = bma_pkg::BMA_OP_CTZ;
      bma_pkg::BMA_OP_CPOPW: o = bma_pkg::BMA_OP_CPOP;
      bma_pkg::BMA_OP_ROLW: o = bma_pkg::BMA_OP_ROL;
      bma_pkg::BMA_OP_RORW: o = bma_pkg::BMA_OP_ROR;
      bma_pkg::BMA_OP_RORIW: o = bma_pkg::BMA_OP_RORI;
      bma_pkg::BMA_OP_PACKW: o = bma_pkg::BMA_OP_PACK;
      default: wd = 1'b0;
    endcase
    if (wd && w32)
      return {1'b1, 64'h0};
    if (wd) begin
      t = model(o, x, y, im, u, 1'b1, c);
      return {t[64], {32{t[31]}}, t[31:0]};
    end
    w = w32 ? 32 : 64;
    m = w32 ? 64'h0000_0000_ffff_ffff : 64'hffff_ffff_ffff_ffff;
    xa = x & m;
    yb = y & m;
    kr = int'(yb[5:0]) & (w - 1);
    ki = int'(im) & (w - 1);
    n = u ? ki : kr;
    ill = w32 && u && im[5] && (o inside {bma_pkg::BMA_OP_BCLR, bma_pkg::BMA_OP_BEXT,
                                          bma_pkg::BMA_OP_BINV, bma_pkg::BMA_OP_BSET});
    lt = $signed(xa << (64 - w)) < $signed(yb << (64 - w));
    p = '0;
    r = '0;
    for (int i = 0; i < w; i++)
      if (yb[i]) p = p ^ ({64'h0, xa} << i);
    case (o)
      bma_pkg::BMA_OP_ANDN: r = xa & ~yb;
      bma_pkg::BMA_OP_ORN: r = xa | ~yb;
      bma_pkg::BMA_OP_XNOR: r = ~(xa ^ yb);
      bma_pkg::BMA_OP_CLZ: begin
        r = 64'(w);
        for (int i = 0; i < w; i++)
          if (xa[i]) r = 64'(w - 1 - i);
      end
      bma_pkg::BMA_OP_CTZ: begin
        r = 64'(w);
        for (int i = w - 1; i >= 0; i--)
          if (xa[i]) r = 64'(i);
      end
      bma_pkg::BMA_OP_CPOP: r = 64'($countones(xa));
      bma_pkg::BMA_OP_MIN: r = lt ? xa : yb;
      bma_pkg::BMA_OP_MAX: r = lt ? yb : xa;
      bma_pkg::BMA_OP_MINU: r = (xa < yb) ? xa : yb;
      bma_pkg::BMA_OP_MAXU: r = (xa < yb) ? yb : xa;
      bma_pkg::BMA_OP_SEXT_BYTE: r = {{56{x[7]}}, x[7:0]};
      bma_pkg::BMA_OP_SEXT_HALF: r = {{48{x[15]}}, x[15:0]};
      bma_pkg::BMA_OP_ZEXT_HALF: r = {48'h0, x[15:0]};
      bma_pkg::BMA_OP_ROL: r = rotl(xa, kr, w, m);
      bma_pkg::BMA_OP_ROR: r = rotl(xa, (w - kr) % w, w, m);
      bma_pkg::BMA_OP_RORI: r = rotl(xa, (w - ki) % w, w, m);
      bma_pkg::BMA_OP_OR_COMBINE: for (int i = 0; i < 8; i++) r[8*i+:8] = {8{|xa[8*i+:8]}};
      bma_pkg::BMA_OP_BYTE_REVERSE: for (int i = 0; i < w / 8; i++) r[8*i+:8] = xa[w-8-8*i+:8];
      bma_pkg::BMA_OP_CLMUL: r = p[63:0];
      bma_pkg::BMA_OP_CLMULH: r = 64'(p >> w);
      bma_pkg::BMA_OP_CLMULR: begin
        ill = c;
        r = 64'(p >> (w - 1));
      end
      bma_pkg::BMA_OP_BCLR: r = xa & ~(64'h1 << n);
      bma_pkg::BMA_OP_BEXT: r = {63'h0, xa[n]};
      bma_pkg::BMA_OP_BINV: r = xa ^ (64'h1 << n);
      bma_pkg::BMA_OP_BSET: r = xa | (64'h1 << n);
      bma_pkg::BMA_OP_PACK: r = w32 ? {32'h0, y[15:0], x[15:0]} : {y[31:0], x[31:0]};
      bma_pkg::BMA_OP_PACKH: r = {48'h0, y[7:0], x[7:0]};
      bma_pkg::BMA_OP_REV_BITS: for (int i = 0; i < w; i++) r[i] = xa[(i & ~7) | (7 - (i & 7))];
      default: r = '0;
    endcase
    return ill ? {1'b1, 64'h0} : {1'b0, r & m};
  endfunction : model

  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input bma_pkg::bma_op_e o, input logic [63:0] x, y, input logic [5:0] im,
                      input logic u, w32, c, v, e);
    @(posedge clk);
    en <= e;
    vld <= v;
    op <= o;
    a <= x;
    b <= y;
    imm <= im;
    ui <= u;
    b32 <= w32;
    cr <= c;
    #1;
    if (pe) begin
      ev = pv;
      ei = pv & pexp[64];
      if (pv) er = pexp[63:0];
      if (pv && !pexp[64]) wexp = pexp[63:0];
    end
    checked++;
    if (vo !== ev || io !== ei || ro !== er) begin
      errors++;
      $display("CHECK FAILED t=%0t valid %b/%b illegal %b/%b result %h/%h", $time, vo, ev, io, ei, ro, er);
    end
    pe = e;
    pv = v;
    pexp = model(o, x, y, im, u, w32, c);
  endtask : send

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    vld <= 1'b0;
    #1;
    checked++;
    if (vo !== 1'b0 || io !== 1'b0 || ro !== 64'h0) begin
      errors++;
      $display("CHECK FAILED t=%0t outputs not cleared by reset", $time);
    end
    {ev, ei, er, pe, wexp} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, vld, ui, b32, cr, a, b, imm, pe, pv, ev, ei, er, wexp, pexp} = '0;
    en = 1'b1;
    op = bma_pkg::BMA_OP_ANDN;
    errors = 0;
    checked = 0;
    void'($urandom(32'h1828));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < oe.num(); k++)
      for (int s = 0; s < 4; s++)
        for (int q = 0; q < 8; q++)
          send(bma_pkg::bma_op_e'(6'(k)), ca[q], cb[q], ci[q], s[0], s[1], q[0], 1'b1, 1'b1);
    for (int k = 0; k < 4000; k++) begin
      oe = bma_pkg::bma_op_e'(6'($urandom_range(oe.num() - 1)));
      send(oe, {$urandom, $urandom}, {$urandom, $urandom}, 6'($urandom), 1'($urandom), 1'($urandom),
           1'($urandom), $urandom_range(3) != 0, $urandom_range(7) != 0);
      if (k == 2000) do_reset();
    end
    send(oe, 64'h0, 64'h0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    #1;
    checked++;
    if (wb !== wexp) begin
      errors++;
      $display("CHECK FAILED t=%0t destination %h expected %h", $time, wb, wexp);
    end
    give_verdict();
  end
endmodule : bit_manipulation_alu_test
`default_nettype wire
